/* File: dv/bus_feeder.sv */
`default_nettype none

module bus_feeder (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       fetch_ready,
  input  wire logic       slow_ack,
  output logic            fetch_valid,
  output logic [7:0]      fetch_byte,
  output logic            bus_ack
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] q[$];
  logic [1:0] ack_cnt = 2'h0;

  initial begin
    fetch_valid = 1'b0;
    fetch_byte = 8'h00;
    bus_ack = 1'b0;
  end

  // A byte stays offered until an edge sees ready; idle data toggles so nothing stale passes.
  always @(posedge clk_sys) begin
    if (fetch_valid && fetch_ready)
      void'(q.pop_front());
    #1;
    fetch_valid = rstn && q.size() > 0;
    fetch_byte = fetch_valid ? q[0] : ~fetch_byte;
    ack_cnt = (ack_cnt == 2'h2) ? 2'h0 : ack_cnt + 2'h1;
    bus_ack = !slow_ack || ack_cnt == 2'h0;
  end
endmodule

`default_nettype wire

/* File: dv/data_transfer_instr_timing_test.sv */
`default_nettype none

bind data_transfer_instr_timing dti_props u_props (.clk_sys, .rstn, .fetch_ready,
  .queue_level, .instr_done, .instr_undefined, .instr_opcode, .instr_cycles, .instr_mem,
  .exec_busy, .narrow_active);

module data_transfer_instr_timing_test;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] cyc;
    logic       w;
    logic       m;
    logic       u;
  } note_t;

  logic       clk_sys = 1'b0;
  logic       rstn = 1'b0;
  logic       narrow = 1'b0;
  logic       slow = 1'b0;
  logic       fetch_valid, bus_ack, fetch_ready, instr_done, instr_undefined;
  logic       instr_word, instr_mem, exec_busy, narrow_active;
  logic [7:0] fetch_byte, instr_opcode, instr_cycles;
  logic [2:0] queue_level;
  logic [2:0] maxlvl = 3'h0;
  note_t      notes[$];
  note_t      got;
  integer     seed = 32'h281d_ace6;
  integer     n_fail = 0;
  integer     n_checks = 0;
  integer     ticks = 0;
  logic [7:0] ops [16] = '{8'h8e, 8'h8c, 8'hc4, 8'hc5, 8'hd7, 8'h8d, 8'h9f, 8'h9e,
                           8'h88, 8'h89, 8'h8a, 8'h8b, 8'h27, 8'hc5, 8'h8e, 8'h89};

  always #2 clk_sys = ~clk_sys;

  bus_feeder u_feed (.clk_sys, .rstn, .fetch_ready, .slow_ack(slow), .fetch_valid,
    .fetch_byte, .bus_ack);

  data_transfer_instr_timing dut (.clk_sys, .rstn, .narrow_bus_pin(narrow), .fetch_valid,
    .fetch_byte, .bus_ack, .fetch_ready, .queue_level, .instr_done, .instr_undefined,
    .instr_opcode, .instr_cycles, .instr_word, .instr_mem, .exec_busy, .narrow_active);

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic note_t expect_of(input logic [7:0] op, input logic m, input logic nar);
    note_t      n;
    logic [7:0] add;
    add = (nar && op[0] && m) ? 8'h04 : 8'h00;
    n.op = op;
    n.w = 1'b0;
    n.m = m;
    n.u = 1'b0;
    case (op)
      8'h8e: n.cyc = m ? (nar ? 8'h0d : 8'h09) : 8'h02;
      8'h8c: n.cyc = m ? (nar ? 8'h0f : 8'h0b) : 8'h02;
      8'hc4, 8'hc5: begin
        n.cyc = m ? (nar ? 8'h1a : 8'h12) : 8'h02;
        n.u = !m;
      end
      8'hd7: n.cyc = nar ? 8'h0f : 8'h0b;
      8'h8d: begin
        n.cyc = 8'h06;
        n.m = 1'b0;
      end
      8'h9f: n.cyc = 8'h02;
      8'h9e: n.cyc = 8'h03;
      8'h88, 8'h89, 8'h8a, 8'h8b: begin
        n.cyc = m ? (op[1] ? 8'h09 : 8'h0c) + add : 8'h02;
        n.w = op[0];
      end
      default: begin
        n.cyc = 8'h01;
        n.u = 1'b1;
      end
    endcase
    return n;
  endfunction

  // Register or memory operand is picked at random; mod 00 avoids the direct form.
  task automatic send(input logic [7:0] op);
    logic [31:0] r;
    logic        mf;
    r = $random(seed);
    mf = op inside {[8'h88:8'h8e], 8'hc4, 8'hc5};
    u_feed.q.push_back(op);
    if (mf)
      u_feed.q.push_back({{2{r[0]}}, 1'b0, r[5:4], 1'b0, r[2:1]});
    notes.push_back(expect_of(op, mf ? !r[0] : op == 8'hd7, narrow));
  endtask

  task automatic phase(input logic nar, input logic slw);
    integer      i;
    logic [31:0] r;
    @(posedge clk_sys);
    #1;
    rstn = 1'b0;
    narrow = nar;
    slow = slw;
    repeat (16) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    check({7'h0, narrow_active}, {7'h0, nar}, "variant");
    maxlvl = 3'h0;
    @(negedge clk_sys);
    for (i = 0; i < 56; i++) begin
      r = $random(seed);
      send(i < 16 ? ops[i] : ops[r[3:0]]);
    end
    while (notes.size() != 0) @(posedge clk_sys);
    check({5'h0, maxlvl}, nar ? 8'h04 : 8'h06, "queue peak");
  endtask

  task automatic end_of_test;
    if (n_fail == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    ticks++;
    if (ticks == 20000) begin
      n_fail++;
      end_of_test();
    end
    if (rstn && queue_level > maxlvl)
      maxlvl = queue_level;
    if (rstn && instr_done === 1'b1) begin
      if (notes.size() == 0) begin
        check({7'h0, instr_done}, 8'h00, "unexpected done");
      end else begin
        got = notes.pop_front();
        check(instr_opcode, got.op, "opcode");
        check({7'h0, instr_undefined}, {7'h0, got.u}, "undefined");
        if (slow && got.m)
          check({7'h0, instr_cycles >= got.cyc && instr_cycles <= got.cyc + 8'h02}, 8'h01, "cycles");
        else
          check(instr_cycles, got.cyc, "cycles");
        if (!got.u) begin
          check({7'h0, instr_word}, {7'h0, got.w}, "word");
          check({7'h0, instr_mem}, {7'h0, got.m}, "memory");
        end
      end
    end
  end

  initial begin
    phase(1'b0, 1'b0);
    phase(1'b1, 1'b0);
    phase(1'b0, 1'b1);
    phase(1'b1, 1'b1);
    end_of_test();
  end
endmodule

`default_nettype wire

/* File: dv/dti_props.sv */
`default_nettype none

module dti_props (
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       fetch_ready,
  input wire logic [2:0] queue_level,
  input wire logic       instr_done,
  input wire logic       instr_undefined,
  input wire logic [7:0] instr_opcode,
  input wire logic [7:0] instr_cycles,
  input wire logic       instr_mem,
  input wire logic       exec_busy,
  input wire logic       narrow_active
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  logic [2:0] cap;
  logic       fin;
  assign cap = narrow_active ? 3'h4 : 3'h6;
  assign fin = instr_done && !instr_undefined;

  // Memory forms may run up to two handshake clocks past their minimum.
  function automatic logic win(input logic [7:0] c, input logic [7:0] lo);
    return c >= lo && c <= lo + 8'h02;
  endfunction

  a_queue_bound: assert property (queue_level <= cap)
    else $error("queue level above capacity");
  a_full_refuse: assert property (queue_level == cap |-> !fetch_ready)
    else $error("fetch offered ready with a full queue");
  a_single_done: assert property (instr_done |=> !instr_done || instr_undefined)
    else $error("defined instruction done on the cycle after a done");
  a_undef_flag: assert property (instr_undefined |-> instr_done && instr_cycles <= 8'h02)
    else $error("undefined flag without a short done");
  a_seg_load: assert property (fin && instr_opcode == 8'h8e |->
      (instr_mem ? win(instr_cycles, narrow_active ? 8'h0d : 8'h09) : instr_cycles == 8'h02))
    else $error("segment load time wrong");
  a_seg_store: assert property (fin && instr_opcode == 8'h8c |->
      (instr_mem ? win(instr_cycles, narrow_active ? 8'h0f : 8'h0b) : instr_cycles == 8'h02))
    else $error("segment store time wrong");
  a_far_load: assert property (fin && instr_opcode[7:1] == 7'h62 |->
      instr_mem && win(instr_cycles, narrow_active ? 8'h1a : 8'h12))
    else $error("far pointer load time wrong");
  a_table_translate_time: assert property (fin && instr_opcode == 8'hd7 |->
      win(instr_cycles, narrow_active ? 8'h0f : 8'h0b))
    else $error("table translate time wrong");
  a_lea_time: assert property (fin && instr_opcode == 8'h8d |-> instr_cycles == 8'h06 && !instr_mem)
    else $error("effective address time wrong");
  a_flags_read: assert property (fin && instr_opcode == 8'h9f |-> instr_cycles == 8'h02)
    else $error("flags read time wrong");
  a_flags_write: assert property (fin && instr_opcode == 8'h9e |-> instr_cycles == 8'h03)
    else $error("flags write time wrong");
  a_busy_ends: assert property ($rose(exec_busy) |-> ##[1:40] instr_done)
    else $error("instruction never finished");
endmodule

`default_nettype wire

/* File: rtl/data_transfer_instr_timing.sv */
// Overview of operation
// - Wide bus variant queues six bytes.
// - Narrow bus variant queues four bytes.
// - Counts are minimums with operands queued.
// - Memory instructions may add two handshake clocks.
// - Load segment register: 2, 9 or 13.
// - Store segment register: 2, 11 or 15.
// - Far load data segment: 18 or 26.
// - Far load extra segment: 18 or 26.
// - Table translate: 11 or 15 cycles.
// - Load effective address: six cycles always.
// - Flags to accumulator high: two cycles.
// - Accumulator high to flags: three cycles.
// - Narrow bus word memory adds four.
`include "dti_cfg.svh"
`default_nettype none

module data_transfer_instr_timing (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       narrow_bus_pin,
  input  wire logic       fetch_valid,
  input  wire logic [7:0] fetch_byte,
  input  wire logic       bus_ack,
  output logic            fetch_ready,
  output logic [2:0]      queue_level,
  output logic            instr_done,
  output logic            instr_undefined,
  output logic [7:0]      instr_opcode,
  output logic [7:0]      instr_cycles,
  output logic            instr_word,
  output logic            instr_mem,
  output logic            exec_busy,
  output logic            narrow_active
);
  import dti_pkg::*;

  core_state_t s;
  core_state_t next_s;
  logic        pop;
  logic        head_valid;
  logic [7:0]  head_byte;
  logic        complete;
  logic        min_reached;

  // Positional literals below list known, has_modrm, has_w, starred, far_ptr,
  // accesses, imm_bytes and the three cycle figures.
  function automatic decode_t decode_opcode(input logic [7:0] opc);
    decode_t d;
    d = '0;
    d.known = 1'b1;
    case (opc)
      `DTI_OPC_MOV_RM_FROM_REG, `DTI_OPC_MOV_RM_FROM_REG | `DTI_OPC_W_BIT: begin
        d = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 2'd0,
              `DTI_CYC_MOV_RM_REG, `DTI_CYC_MOV_RM_MEM, `DTI_CYC_MOV_RM_MEM};
      end
      `DTI_OPC_MOV_REG_FROM_RM, `DTI_OPC_MOV_REG_FROM_RM | `DTI_OPC_W_BIT: begin
        d = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 2'd0,
              `DTI_CYC_MOV_REG_REG, `DTI_CYC_MOV_REG_MEM, `DTI_CYC_MOV_REG_MEM};
      end
      `DTI_OPC_XCHG_RM, `DTI_OPC_XCHG_RM | `DTI_OPC_W_BIT: begin
        d = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 2'd0,
              `DTI_CYC_XCHG_REG, `DTI_CYC_XCHG_MEM, `DTI_CYC_XCHG_MEM};
      end
      `DTI_OPC_MOV_ACC_FROM_M, `DTI_OPC_MOV_ACC_FROM_M | `DTI_OPC_W_BIT: begin
        d = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 2'd2,
              `DTI_CYC_MOV_ACC_M, `DTI_CYC_MOV_ACC_M, `DTI_CYC_MOV_ACC_M};
      end
      `DTI_OPC_MOV_M_FROM_ACC, `DTI_OPC_MOV_M_FROM_ACC | `DTI_OPC_W_BIT: begin
        d = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 2'd2,
              `DTI_CYC_MOV_M_ACC, `DTI_CYC_MOV_M_ACC, `DTI_CYC_MOV_M_ACC};
      end
      `DTI_OPC_RM_TO_SEG: begin
        d = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 2'd0,
              `DTI_CYC_SEG_REG, `DTI_CYC_TO_SEG_M16, `DTI_CYC_TO_SEG_M8};
      end
      `DTI_OPC_SEG_TO_RM: begin
        d = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 2'd0,
              `DTI_CYC_SEG_REG, `DTI_CYC_FROM_SEG_M16, `DTI_CYC_FROM_SEG_M8};
      end
      `DTI_OPC_LEA: begin
        d = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'd0,
              `DTI_CYC_LEA, `DTI_CYC_LEA, `DTI_CYC_LEA};
      end
      `DTI_OPC_LOAD_FAR_DS, `DTI_OPC_LOAD_FAR_ES: begin
        d = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 2'd0,
              `DTI_CYC_FAR_M16, `DTI_CYC_FAR_M16, `DTI_CYC_FAR_M8};
      end
      `DTI_OPC_TABLE_XLATE: begin
        d = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'd0,
              `DTI_CYC_TABLE_TRANSLATE_16, `DTI_CYC_TABLE_TRANSLATE_16, `DTI_CYC_TABLE_TRANSLATE_8};
      end
      `DTI_OPC_PUSH_FLAGS: begin
        d = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'd0,
              `DTI_CYC_PUSHF_16, `DTI_CYC_PUSHF_16, `DTI_CYC_PUSHF_8};
      end
      `DTI_OPC_POP_FLAGS: begin
        d = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'd0,
              `DTI_CYC_POPF_16, `DTI_CYC_POPF_16, `DTI_CYC_POPF_8};
      end
      `DTI_OPC_ACC_HI_TO_FLAGS: begin
        d.cyc_reg = `DTI_CYC_ACC_HI_FLAGS;
      end
      `DTI_OPC_FLAGS_TO_ACC_HI: begin
        d.cyc_reg = `DTI_CYC_FLAGS_ACC_HI;
      end
      // Jumps and calls lie outside this table and decode as undefined
      // so no destination fetch is ever counted here.
      default: begin
        d.known = 1'b0;
      end
    endcase
    return d;
  endfunction

  // Mod 11 names a register operand; every other mod code names a memory operand, which all but load effective address reach.
  function automatic logic reg_form(input logic [7:0] modrm);
    return modrm[`DTI_MOD_MSB:`DTI_MOD_LSB] == `DTI_MOD_REG;
  endfunction

  // Direct addressing under mod 00 carries a two-byte address.
  function automatic logic [1:0] disp_bytes(input logic [7:0] modrm);
    logic [1:0] md;
    md = modrm[`DTI_MOD_MSB:`DTI_MOD_LSB];
    if (reg_form(modrm)) begin
      return 2'd0;
    end else if (md == `DTI_MOD_DISP8) begin
      return 2'd1;
    end else if (md == `DTI_MOD_NO_DISP && modrm[2:0] != `DTI_RM_DIRECT) begin
      return 2'd0;
    end
    return 2'd2;
  endfunction

  // The memory column differs by bus width; the register column never does.
  function automatic logic [7:0] pick_target(input decode_t d, input logic mem_form,
                                             input logic narrow, input logic word);
    logic [7:0] t;
    t = mem_form ? (narrow ? d.cyc_mem8 : d.cyc_mem16) : d.cyc_reg;
    // Word memory transfer on narrow bus.
    if (narrow && d.starred && word && mem_form) begin
      t = t + `DTI_CYC_WORD_ADD;
    end
    return t;
  endfunction

  // Saturating keeps a long stall from wrapping into a small, plausible count.
  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    return (v == 8'hFF) ? v : v + 8'd1;
  endfunction

  // The queue follows the settled variant, never the raw strap, so capacity
  // cannot flicker while the strap pin is still bouncing.
  prefetch_queue u_queue (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .narrow     (s.narrow),
    .push_valid (fetch_valid),
    .push_byte  (fetch_byte),
    .pop        (pop),
    .push_ready (fetch_ready),
    .head_valid (head_valid),
    .head_byte  (head_byte),
    .level      (queue_level)
  );

  // The cycle in which the opcode is taken counts as cycle one.
  always_comb begin
    next_s = s;
    pop = 1'b0;
    complete = 1'b0;
    min_reached = 1'b0;
    next_s.sync = {s.sync[1:0], narrow_bus_pin};
    // The variant only changes once two settled samples agree.
    if (s.sync[1] == s.sync[2]) begin
      next_s.narrow = s.sync[2];
    end
    next_s.done = 1'b0;
    next_s.undef = 1'b0;
    unique case (s.st)
      ST_OPCODE: begin
        if (head_valid) begin
          pop = 1'b1;
          next_s.opcode = head_byte;
          next_s.dec = decode_opcode(head_byte);
          // Low bit picks byte or word.
          next_s.word = next_s.dec.has_w && head_byte[0];
          next_s.elapsed = 8'd1;
          next_s.extra = 2'd0;
          next_s.need = 2'd0;
          next_s.mem = 1'b0;
          next_s.busy = 1'b1;
          // An unknown opcode is reported at once so that the queue keeps moving.
          if (!next_s.dec.known) begin
            next_s.undef = 1'b1;
            next_s.done = 1'b1;
            next_s.done_opcode = head_byte;
            next_s.done_cycles = `DTI_CYC_UNDEF;
            next_s.done_word = 1'b0;
            next_s.done_mem = 1'b0;
            next_s.busy = 1'b0;
          end else if (next_s.dec.has_modrm) begin
            next_s.st = ST_MODRM;
          end else begin
            next_s.mem = next_s.dec.accesses;
            next_s.need = next_s.dec.imm_bytes;
            next_s.target = pick_target(next_s.dec, next_s.mem, s.narrow, next_s.word);
            next_s.st = ST_EXEC;
          end
        end
      end
      ST_MODRM: begin
        next_s.elapsed = sat_inc(s.elapsed);
        if (head_valid) begin
          pop = 1'b1;
          next_s.mem = !reg_form(head_byte);
          // Register form of far load.
          // Only the mod/reg/rm byte is taken; a register form has no displacement.
          if (s.dec.far_ptr && !next_s.mem) begin
            next_s.undef = 1'b1;
            next_s.done = 1'b1;
            next_s.done_opcode = s.opcode;
            next_s.done_cycles = next_s.elapsed;
            next_s.done_word = 1'b0;
            next_s.done_mem = 1'b0;
            next_s.busy = 1'b0;
            next_s.st = ST_OPCODE;
          end else begin
            next_s.need = disp_bytes(head_byte);
            next_s.target = pick_target(s.dec, next_s.mem, s.narrow, s.word);
            next_s.mem = next_s.mem && s.dec.accesses;
            next_s.st = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        next_s.elapsed = sat_inc(s.elapsed);
        // A missing operand byte stalls.
        // Operand bytes are taken one per clock as they arrive; a late byte
        // stretches the count, which is why the figures are minimums.
        if (s.need != 2'd0 && head_valid) begin
          pop = 1'b1;
          next_s.need = s.need - 2'd1;
        end
      end
      // Code 3 is never entered; should it appear, return to idle rather than hang.
      default: begin
        next_s.st = ST_OPCODE;
        next_s.busy = 1'b0;
      end
    endcase
    min_reached = (next_s.st == ST_EXEC) && (next_s.need == 2'd0) &&
                  (next_s.elapsed >= next_s.target);
    // The ceiling trades exactness for a bound: a silent bus costs two clocks,
    // never a hang.
    // Wait for handshake, at most two clocks.
    complete = min_reached && (!next_s.mem || bus_ack || s.extra == `DTI_EXTRA_MAX);
    if (complete) begin
      next_s.done = 1'b1;
      next_s.done_opcode = next_s.opcode;
      next_s.done_cycles = next_s.elapsed;
      next_s.done_word = next_s.word;
      next_s.done_mem = next_s.mem;
      next_s.busy = 1'b0;
      next_s.st = ST_OPCODE;
    end else if (min_reached) begin
      next_s.extra = s.extra + 2'd1;
    end
  end

  // One register holds all state, so reset clears every output on the same edge.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs read the state register directly, with no logic after the flops.
  assign instr_done      = s.done;
  assign instr_undefined = s.undef;
  assign instr_opcode    = s.done_opcode;
  assign instr_cycles    = s.done_cycles;
  assign instr_word      = s.done_word;
  assign instr_mem       = s.done_mem;
  assign exec_busy       = s.busy;
  assign narrow_active   = s.narrow;

endmodule

`default_nettype wire

/* File: rtl/prefetch_queue.sv */
`include "dti_cfg.svh"
`default_nettype none

module prefetch_queue (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       narrow,
  input  wire logic       push_valid,
  input  wire logic [7:0] push_byte,
  input  wire logic       pop,
  output logic            push_ready,
  output logic            head_valid,
  output logic [7:0]      head_byte,
  output logic [2:0]      level
);
  import dti_pkg::*;

  logic [7:0]   mem [`DTI_QDEPTH_MAX];
  queue_state_t s;
  queue_state_t next_s;
  logic         do_push;
  logic         do_pop;
  logic [2:0]   cap;

  function automatic logic [2:0] wrap_inc(input logic [2:0] p);
    return (p == 3'(`DTI_QDEPTH_MAX - 1)) ? 3'd0 : p + 3'd1;
  endfunction

  // Six bytes on the wide bus.
  // Four bytes on the narrow bus.
  assign cap        = narrow ? `DTI_QDEPTH_NARROW : `DTI_QDEPTH_WIDE;
  assign do_push    = push_valid && s.ready;
  assign do_pop     = pop && (s.count != 3'd0);
  assign push_ready = s.ready;
  assign head_valid = (s.count != 3'd0);
  assign head_byte  = mem[s.rd_ptr];
  assign level      = s.count;

  always_comb begin
    next_s = s;
    if (do_push) begin
      next_s.wr_ptr = wrap_inc(s.wr_ptr);
    end
    if (do_pop) begin
      next_s.rd_ptr = wrap_inc(s.rd_ptr);
    end
    next_s.count = s.count + 3'(do_push) - 3'(do_pop);
    // Ready is registered, so it is judged on the count that will stand next cycle.
    next_s.ready = (next_s.count < cap);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Storage carries no reset; only the pointers and count say what is valid.
  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem[s.wr_ptr] <= push_byte;
    end
  end

endmodule

`default_nettype wire

/* File: shared/dti_cfg.svh */
`ifndef DTI_CFG_SVH
`define DTI_CFG_SVH

// Prefetch queue depth for each bus width.
`define DTI_QDEPTH_WIDE        3'd6
`define DTI_QDEPTH_NARROW      3'd4
`define DTI_QDEPTH_MAX         6

// Opcodes; forms with a w bit are given with w equal to 0.
`define DTI_OPC_MOV_RM_FROM_REG 8'h88
`define DTI_OPC_MOV_REG_FROM_RM 8'h8A
`define DTI_OPC_XCHG_RM         8'h86
`define DTI_OPC_MOV_ACC_FROM_M  8'hA0
`define DTI_OPC_MOV_M_FROM_ACC  8'hA2
`define DTI_OPC_SEG_TO_RM       8'h8C
`define DTI_OPC_LEA             8'h8D
`define DTI_OPC_RM_TO_SEG       8'h8E
`define DTI_OPC_LOAD_FAR_ES     8'hC4
`define DTI_OPC_LOAD_FAR_DS     8'hC5
`define DTI_OPC_TABLE_XLATE     8'hD7
`define DTI_OPC_PUSH_FLAGS      8'h9C
`define DTI_OPC_POP_FLAGS       8'h9D
`define DTI_OPC_ACC_HI_TO_FLAGS 8'h9E
`define DTI_OPC_FLAGS_TO_ACC_HI 8'h9F
`define DTI_OPC_W_BIT           8'h01

// Field positions and codes of the mod/reg/rm byte.
`define DTI_MOD_MSB            7
`define DTI_MOD_LSB            6
`define DTI_MOD_REG            2'b11
`define DTI_MOD_NO_DISP        2'b00
`define DTI_MOD_DISP8          2'b01
`define DTI_RM_DIRECT          3'b110

// Minimum cycle counts: register form, memory form 16-bit bus, memory form 8-bit bus.
`define DTI_CYC_MOV_RM_REG     8'd2
`define DTI_CYC_MOV_RM_MEM     8'd12
`define DTI_CYC_MOV_REG_REG    8'd2
`define DTI_CYC_MOV_REG_MEM    8'd9
`define DTI_CYC_XCHG_REG       8'd4
`define DTI_CYC_XCHG_MEM       8'd17
`define DTI_CYC_MOV_ACC_M      8'd8
`define DTI_CYC_MOV_M_ACC      8'd9
`define DTI_CYC_SEG_REG        8'd2
`define DTI_CYC_TO_SEG_M16     8'd9
`define DTI_CYC_TO_SEG_M8      8'd13
`define DTI_CYC_FROM_SEG_M16   8'd11
`define DTI_CYC_FROM_SEG_M8    8'd15
`define DTI_CYC_LEA            8'd6
`define DTI_CYC_FAR_M16        8'd18
`define DTI_CYC_FAR_M8         8'd26
`define DTI_CYC_TABLE_TRANSLATE_16        8'd11
`define DTI_CYC_TABLE_TRANSLATE_8         8'd15
`define DTI_CYC_PUSHF_16       8'd9
`define DTI_CYC_PUSHF_8        8'd13
`define DTI_CYC_POPF_16        8'd8
`define DTI_CYC_POPF_8         8'd12
`define DTI_CYC_ACC_HI_FLAGS   8'd3
`define DTI_CYC_FLAGS_ACC_HI   8'd2
`define DTI_CYC_WORD_ADD       8'd4
`define DTI_CYC_UNDEF          8'd1
`define DTI_EXTRA_MAX          2'd2

`endif

/* File: shared/dti_pkg.sv */
`default_nettype none

package dti_pkg;

  typedef enum logic [1:0] {
    ST_OPCODE,
    ST_MODRM,
    ST_EXEC
  } exec_state_t;

  typedef struct packed {
    logic       known;
    logic       has_modrm;
    logic       has_w;
    logic       starred;
    logic       far_ptr;
    logic       accesses;
    logic [1:0] imm_bytes;
    logic [7:0] cyc_reg;
    logic [7:0] cyc_mem16;
    logic [7:0] cyc_mem8;
  } decode_t;

  typedef struct packed {
    logic [2:0] count;
    logic [2:0] rd_ptr;
    logic [2:0] wr_ptr;
    logic       ready;
  } queue_state_t;

  typedef struct packed {
    exec_state_t st;
    logic [2:0]  sync;
    logic        narrow;
    logic [7:0]  opcode;
    decode_t     dec;
    logic        word;
    logic        mem;
    logic [1:0]  need;
    logic [7:0]  elapsed;
    logic [7:0]  target;
    logic [1:0]  extra;
    logic        done;
    logic        undef;
    logic [7:0]  done_opcode;
    logic [7:0]  done_cycles;
    logic        done_word;
    logic        done_mem;
    logic        busy;
  } core_state_t;

endpackage

`default_nettype wire
